// ==== rtl/sdf_pkg.sv ====
package sdf_pkg;
  // register byte offsets
  localparam logic [5:0] SDF_OFS_RAW  = 6'h00;
  localparam logic [5:0] SDF_OFS_MASK = 6'h04;
  localparam logic [5:0] SDF_OFS_CLR  = 6'h08;
  localparam logic [5:0] SDF_OFS_THR  = 6'h38;
  localparam int         SDF_ADDR_W   = 6;
  localparam int         SDF_DATA_W   = 32;
  localparam int         SDF_NFLAGS   = 15;
  // flag positions
  localparam int SDF_B_REPLY_CRC   = 14;
  localparam int SDF_B_LINE3_LOW   = 13;
  localparam int SDF_B_LINE3_HIGH  = 12;
  localparam int SDF_B_CMD_SENT    = 11;
  localparam int SDF_B_BUSY_REL    = 10;
  localparam int SDF_B_CARD_TX_ERR = 9;
  localparam int SDF_B_CARD_RX_ERR = 8;
  localparam int SDF_B_BUS_RX_ERR  = 7;
  localparam int SDF_B_BUS_TX_ERR  = 6;
  localparam int SDF_B_RX_FULL     = 5;
  localparam int SDF_B_RX_LEVEL    = 4;
  localparam int SDF_B_RX_NONEMPTY = 3;
  localparam int SDF_B_TX_SPACE    = 2;
  localparam int SDF_B_TX_ROOM     = 1;
  localparam int SDF_B_TX_DRAINED  = 0;
  // threshold register fields
  localparam int SDF_THR_RX_LSB = 8;
  localparam int SDF_THR_TX_LSB = 0;
  localparam int SDF_THR_W      = 8;
  localparam int SDF_CMP_W      = 9;
  // reset values
  localparam logic [14:0] SDF_MASK_RST   = 15'h7fff;
  localparam logic [14:0] SDF_FLAGS_RST  = 15'h0000;
  localparam logic [7:0]  SDF_TX_THR_RST = 8'h40;
  localparam logic [7:0]  SDF_RX_THR_RST = 8'h00;
  // bus-side access widths
  typedef enum logic [1:0] {SDF_SZ_BYTE, SDF_SZ_HALF, SDF_SZ_WORD, SDF_SZ_NONE} sdf_size_t;
endpackage : sdf_pkg

// ==== rtl/sdf_queue_watch.sv ====
`timescale 1ns/1ns
module sdf_queue_watch
  import sdf_pkg::*;
#(
  parameter int QUEUE_BYTES = 64,
  parameter int LW          = 7
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [LW-1:0] level,
  input  wire logic          bus_acc,
  input  wire sdf_size_t     bus_size,
  output logic               empty,
  output logic               full,
  output logic               went_empty,
  output logic               went_full,
  output logic               left_empty,
  output logic               left_full,
  output logic               misaligned
);
  logic      empty_prev_ff;
  logic      full_prev_ff;
  logic [1:0] ptr_ff;
  sdf_size_t last_size_ff;
  logic [1:0] step;

  assign empty      = (level == '0);
  assign full       = (level == LW'(QUEUE_BYTES));
  assign went_empty = empty & ~empty_prev_ff;
  assign went_full  = full & ~full_prev_ff;
  assign left_empty = ~empty & empty_prev_ff;
  assign left_full  = ~full & full_prev_ff;
  assign step       = (bus_size == SDF_SZ_BYTE) ? 2'h1 :
                      (bus_size == SDF_SZ_HALF) ? 2'h2 : 2'h0;
  // width change while the byte pointer is off byte zero
  assign misaligned = bus_acc & (bus_size != last_size_ff) & (ptr_ff != 2'h0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      empty_prev_ff <= 1'b1;
      full_prev_ff  <= 1'b0;
    end else begin
      empty_prev_ff <= empty;
      full_prev_ff  <= full;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_ff       <= 2'h0;
      last_size_ff <= SDF_SZ_WORD;
    end else if (bus_acc) begin
      ptr_ff       <= ptr_ff + step;
      last_size_ff <= bus_size;
    end
  end
endmodule : sdf_queue_watch

// ==== rtl/sdf_event_flags.sv ====
// Notes on behaviour
// RULE_01: reply checksum failure sets flag bit 14.
// RULE_02: data machine idle with line three low sets bit 13.
// RULE_03: data machine idle with line three high sets bit 12.
// RULE_04: command fully sent sets bit 11.
// RULE_05: card busy ending sets bit 10.
// RULE_06: card-side transmit underrun bit 9, receive overrun bit 8.
// RULE_07: bus-side receive underrun bit 7, transmit overrun bit 6.
// RULE_08: bus access width change off byte zero counts as misaligned.
// RULE_09: receive queue becoming full sets bit 5.
// RULE_10: receive byte count above receive threshold sets bit 4.
// RULE_11: receive queue leaving empty sets bit 3.
// RULE_12: transmit queue leaving full sets bit 2.
// RULE_13: transmit free space above transmit threshold sets bit 1.
// RULE_14: transmit queue becoming empty sets bit 0.
// RULE_15: raw unmasked flags readable in a read-only register.
// RULE_16: mask bit one blocks flag from interrupt, zero passes it.
// RULE_17: writing one to clear register clears flag; zero does nothing.
// RULE_18: flags latch until cleared and read zero after reset.
`timescale 1ns/1ns
module sdf_event_flags
  import sdf_pkg::*;
#(
  parameter int QUEUE_BYTES = 64,
  parameter int LW          = $clog2(QUEUE_BYTES + 1)
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [SDF_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [SDF_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [SDF_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  reply_crc_fail,
  input  wire logic                  data_sm_idle,
  input  wire logic                  card_data_line_three,
  input  wire logic                  cmd_sent,
  input  wire logic                  card_busy,
  input  wire logic                  card_tx_pop,
  input  wire logic                  card_rx_push,
  input  wire logic                  bus_rx_pop,
  input  wire sdf_size_t             bus_rx_size,
  input  wire logic                  bus_tx_push,
  input  wire sdf_size_t             bus_tx_size,
  input  wire logic [LW-1:0]         rx_level,
  input  wire logic [LW-1:0]         tx_level,
  output logic                       irq
);
  if (QUEUE_BYTES < 4 || QUEUE_BYTES > 256 || (QUEUE_BYTES % 4) != 0 ||
      LW != $clog2(QUEUE_BYTES + 1)) begin : g_bad_param
    $error("sdf_event_flags: queue size must be 4..256 bytes, multiple of 4");
  end

  logic [SDF_NFLAGS-1:0] flags_ff;
  logic [SDF_NFLAGS-1:0] mask_ff;
  logic [SDF_THR_W-1:0]  rx_thr_ff;
  logic [SDF_THR_W-1:0]  tx_thr_ff;
  logic                  wait_ff;
  logic [SDF_DATA_W-1:0] rdata_ff;
  logic                  irq_ff;
  logic                  busy_prev_ff;

  // ---------------- bus slave ----------------
  // one wait cycle per access: request seen, then waitrequest drops for one edge
  wire req       = avs_read | avs_write;
  wire wr_commit = avs_write & ~wait_ff;
  wire sel_raw   = (avs_address == SDF_OFS_RAW);
  wire sel_mask  = (avs_address == SDF_OFS_MASK);
  wire sel_clr   = (avs_address == SDF_OFS_CLR);
  wire sel_thr   = (avs_address == SDF_OFS_THR);
  wire [SDF_DATA_W-1:0] be_bits = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [SDF_DATA_W-1:0] wmask   = avs_writedata & be_bits;
  wire [SDF_NFLAGS-1:0] clr_vec = (wr_commit & sel_clr) ? wmask[SDF_NFLAGS-1:0] : '0;

  // RULE_15 raw flags readback
  wire [SDF_DATA_W-1:0] rd_mux =
    sel_raw  ? {{(SDF_DATA_W-SDF_NFLAGS){1'b0}}, flags_ff} :
    sel_mask ? {{(SDF_DATA_W-SDF_NFLAGS){1'b0}}, mask_ff}  :
    sel_thr  ? {16'h0000, rx_thr_ff, tx_thr_ff}            : '0;

  wire nxt_wait = ~(req & wait_ff);
  wire [SDF_DATA_W-1:0] nxt_rdata = (avs_read & wait_ff) ? rd_mux : rdata_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // ---------------- mask and thresholds ----------------
  wire [SDF_NFLAGS-1:0] be_mask = be_bits[SDF_NFLAGS-1:0];
  wire [SDF_NFLAGS-1:0] nxt_mask =
    (wr_commit & sel_mask) ? ((mask_ff & ~be_mask) | (avs_writedata[SDF_NFLAGS-1:0] & be_mask))
                           : mask_ff;
  wire [SDF_THR_W-1:0] nxt_rx_thr = (wr_commit & sel_thr & avs_byteenable[1]) ?
    avs_writedata[SDF_THR_RX_LSB +: SDF_THR_W] : rx_thr_ff;
  wire [SDF_THR_W-1:0] nxt_tx_thr = (wr_commit & sel_thr & avs_byteenable[0]) ?
    avs_writedata[SDF_THR_TX_LSB +: SDF_THR_W] : tx_thr_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_ff   <= SDF_MASK_RST;
      rx_thr_ff <= SDF_RX_THR_RST;
      tx_thr_ff <= SDF_TX_THR_RST;
    end else begin
      mask_ff   <= nxt_mask;
      rx_thr_ff <= nxt_rx_thr;
      tx_thr_ff <= nxt_tx_thr;
    end
  end

  // ---------------- queue watchers ----------------
  logic tx_empty, tx_full, tx_went_empty, tx_left_full, tx_mis;
  logic rx_empty, rx_full, rx_went_full, rx_left_empty, rx_mis;

  // RULE_08 misalignment tracked per queue
  sdf_queue_watch #(.QUEUE_BYTES(QUEUE_BYTES), .LW(LW)) u_tx_watch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .level      (tx_level),
    .bus_acc    (bus_tx_push),
    .bus_size   (bus_tx_size),
    .empty      (tx_empty),
    .full       (tx_full),
    .went_empty (tx_went_empty),
    .went_full  (),
    .left_empty (),
    .left_full  (tx_left_full),
    .misaligned (tx_mis)
  );

  sdf_queue_watch #(.QUEUE_BYTES(QUEUE_BYTES), .LW(LW)) u_rx_watch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .level      (rx_level),
    .bus_acc    (bus_rx_pop),
    .bus_size   (bus_rx_size),
    .empty      (rx_empty),
    .full       (rx_full),
    .went_empty (),
    .went_full  (rx_went_full),
    .left_empty (rx_left_empty),
    .left_full  (),
    .misaligned (rx_mis)
  );

  // thresholds compare in a common width so small queues still work
  wire [LW-1:0]        tx_free   = LW'(QUEUE_BYTES) - tx_level;
  wire [SDF_CMP_W-1:0] rx_cnt_w  = SDF_CMP_W'(rx_level);
  wire [SDF_CMP_W-1:0] tx_free_w = SDF_CMP_W'(tx_free);
  wire [SDF_CMP_W-1:0] rx_thr_w  = SDF_CMP_W'(rx_thr_ff);
  wire [SDF_CMP_W-1:0] tx_thr_w  = SDF_CMP_W'(tx_thr_ff);

  // ---------------- event sources ----------------
  logic [SDF_NFLAGS-1:0] set_vec;
  // RULE_01 checksum failure
  assign set_vec[SDF_B_REPLY_CRC]   = reply_crc_fail;
  // RULE_02 line three low
  assign set_vec[SDF_B_LINE3_LOW]   = data_sm_idle & ~card_data_line_three;
  // RULE_03 line three high
  assign set_vec[SDF_B_LINE3_HIGH]  = data_sm_idle & card_data_line_three;
  // RULE_04 command sent
  assign set_vec[SDF_B_CMD_SENT]    = cmd_sent;
  // RULE_05 busy falling edge
  assign set_vec[SDF_B_BUSY_REL]    = busy_prev_ff & ~card_busy;
  // RULE_06 card-side queue errors
  assign set_vec[SDF_B_CARD_TX_ERR] = card_tx_pop & tx_empty;
  assign set_vec[SDF_B_CARD_RX_ERR] = card_rx_push & rx_full;
  // RULE_07 bus-side queue errors
  assign set_vec[SDF_B_BUS_RX_ERR]  = bus_rx_pop & (rx_empty | rx_mis);
  assign set_vec[SDF_B_BUS_TX_ERR]  = bus_tx_push & (tx_full | tx_mis);
  // RULE_09 receive full
  assign set_vec[SDF_B_RX_FULL]     = rx_went_full;
  // RULE_10 receive level
  assign set_vec[SDF_B_RX_LEVEL]    = rx_cnt_w > rx_thr_w;
  // RULE_11 receive non-empty
  assign set_vec[SDF_B_RX_NONEMPTY] = rx_left_empty;
  // RULE_12 transmit space
  assign set_vec[SDF_B_TX_SPACE]    = tx_left_full;
  // RULE_13 transmit room
  assign set_vec[SDF_B_TX_ROOM]     = tx_free_w > tx_thr_w;
  // RULE_14 transmit drained
  assign set_vec[SDF_B_TX_DRAINED]  = tx_went_empty;

  // RULE_17 RULE_18 set beats a clear in the same cycle
  wire [SDF_NFLAGS-1:0] nxt_flags = (flags_ff & ~clr_vec) | set_vec;
  // RULE_16 masked interrupt
  wire nxt_irq = |(nxt_flags & ~nxt_mask);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_ff     <= SDF_FLAGS_RST;
      irq_ff       <= 1'b0;
      busy_prev_ff <= 1'b0;
    end else begin
      flags_ff     <= nxt_flags;
      irq_ff       <= nxt_irq;
      busy_prev_ff <= card_busy;
    end
  end

  assign irq = irq_ff;

  // ---------------- assertions ----------------
  a_crc_sets_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    reply_crc_fail |=> flags_ff[SDF_B_REPLY_CRC])
    else $error("checksum failure did not set flag");

  a_line3_low_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    data_sm_idle && !card_data_line_three |=> flags_ff[SDF_B_LINE3_LOW])
    else $error("line three low event missing");

  a_line3_high_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    data_sm_idle && card_data_line_three |=> flags_ff[SDF_B_LINE3_HIGH])
    else $error("line three high event missing");

  a_cmd_sent_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    cmd_sent |=> flags_ff[SDF_B_CMD_SENT])
    else $error("command sent event missing");

  a_busy_release_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    $fell(card_busy) |=> flags_ff[SDF_B_BUSY_REL])
    else $error("busy release event missing");

  a_card_tx_error: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    card_tx_pop && tx_level == '0 |=> flags_ff[SDF_B_CARD_TX_ERR])
    else $error("card-side transmit error missing");

  a_bus_tx_error: assert property (@(posedge sys_clk) disable iff (rst) // RULE_07
    bus_tx_push && tx_level == LW'(QUEUE_BYTES) |=> flags_ff[SDF_B_BUS_TX_ERR])
    else $error("bus-side transmit error missing");

  a_rx_full_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
    $rose(rx_level == LW'(QUEUE_BYTES)) |=> flags_ff[SDF_B_RX_FULL])
    else $error("receive full event missing");

  a_tx_drained_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE_14
    $rose(tx_level == '0) |=> flags_ff[SDF_B_TX_DRAINED])
    else $error("transmit drained event missing");

  a_clear_one_bit: assert property (@(posedge sys_clk) disable iff (rst) // RULE_17
    avs_write && !wait_ff && sel_clr && avs_byteenable[0] && avs_writedata[0] &&
    !set_vec[0] |=> !flags_ff[0])
    else $error("clear write left flag set");

  a_flag_holds: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
    flags_ff[SDF_B_CMD_SENT] && !(avs_write && sel_clr) |=> flags_ff[SDF_B_CMD_SENT])
    else $error("flag dropped without clear");

  a_mask_blocks_irq: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
    mask_ff == '1 && !(avs_write && sel_mask) |=> !irq)
    else $error("interrupt raised while all masked");

  a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
    req && wait_ff |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  c_read_raw: cover property (@(posedge sys_clk) disable iff (rst)
    avs_read && sel_raw && !wait_ff && avs_readdata != '0);
  c_clear_write: cover property (@(posedge sys_clk) disable iff (rst)
    wr_commit && sel_clr);
  c_irq_rise: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
  c_misaligned: cover property (@(posedge sys_clk) disable iff (rst) tx_mis);
endmodule : sdf_event_flags

// ==== dv/sdf_card_model.sv ====
`timescale 1ns/1ns
module sdf_card_model (
  input  wire logic sys_clk,
  output logic      reply_crc_fail,
  output logic      data_sm_idle,
  output logic      card_data_line_three,
  output logic      cmd_sent,
  output logic      card_busy,
  output logic      card_tx_pop,
  output logic      card_rx_push
);
  initial begin
    {reply_crc_fail, data_sm_idle, cmd_sent, card_busy, card_tx_pop, card_rx_push} = '0;
    // line three rests high on its pull-up between commands
    card_data_line_three = 1'b1;
  end
  // k: 0 crc fail, 1 cmd done, 2 busy, 3/4 idle with line low/high, 5 pop, 6 push
  task automatic act(input int k);
    @(posedge sys_clk);
    case (k)
      0: reply_crc_fail <= 1'b1;
      1: cmd_sent <= 1'b1;
      2: card_busy <= 1'b1;
      3, 4: begin
        data_sm_idle         <= 1'b1;
        card_data_line_three <= (k == 4);
      end
      5: card_tx_pop <= 1'b1;
      default: card_rx_push <= 1'b1;
    endcase
    // busy held a few cycles so only its end may raise the flag
    repeat ((k == 2) ? 3 : 1) @(posedge sys_clk);
    {reply_crc_fail, data_sm_idle, cmd_sent, card_busy, card_tx_pop, card_rx_push} <= '0;
    card_data_line_three <= 1'b1;
  endtask : act
endmodule : sdf_card_model

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
  import sdf_pkg::*;
  localparam int QB = 64;
  localparam int LW = $clog2(QB + 1);
  logic                  sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [SDF_ADDR_W-1:0] avs_address;
  logic [SDF_DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]            avs_byteenable, be_q;
  logic                  bus_rx_pop, bus_tx_push;
  sdf_size_t             bus_rx_size, bus_tx_size;
  logic [LW-1:0]         rx_level, tx_level;
  logic                  crc_w, idle_w, line3_w, cmd_w, busy_w, tpop_w, rpush_w;
  int                    miscompares, tests_run;

  sdf_card_model card (.sys_clk(sys_clk), .reply_crc_fail(crc_w), .data_sm_idle(idle_w),
    .card_data_line_three(line3_w), .cmd_sent(cmd_w), .card_busy(busy_w),
    .card_tx_pop(tpop_w), .card_rx_push(rpush_w));

  sdf_event_flags #(.QUEUE_BYTES(QB), .LW(LW)) DUT (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reply_crc_fail(crc_w), .data_sm_idle(idle_w), .card_data_line_three(line3_w),
    .cmd_sent(cmd_w), .card_busy(busy_w), .card_tx_pop(tpop_w), .card_rx_push(rpush_w),
    .bus_rx_pop(bus_rx_pop), .bus_rx_size(bus_rx_size), .bus_tx_push(bus_tx_push),
    .bus_tx_size(bus_tx_size), .rx_level(rx_level), .tx_level(tx_level), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be_q;
    avs_write      <= w;
    avs_read       <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(n, e, v);
  endtask : rdc

  task automatic flag(input string n, input int b, input logic e);
    logic [31:0] v;
    bus(1'b0, SDF_OFS_RAW, 32'h0, v);
    chk(n, {31'h0, e}, {31'h0, v[b]});
  endtask : flag

  task automatic irq_is(input string n, input logic e);
    // mask and clear settle over an edge or two before irq follows
    repeat (2) @(posedge sys_clk);
    #1 chk(n, {31'h0, e}, {31'h0, irq});
  endtask : irq_is

  task automatic lv(input int r, input int t);
    @(posedge sys_clk);
    rx_level <= LW'(r);
    tx_level <= LW'(t);
    @(posedge sys_clk);
  endtask : lv

  task automatic bq(input logic tx, input sdf_size_t sz);
    @(posedge sys_clk);
    bus_tx_push <= tx;
    bus_rx_pop  <= !tx;
    bus_tx_size <= sz;
    bus_rx_size <= sz;
    @(posedge sys_clk);
    bus_tx_push <= 1'b0;
    bus_rx_pop  <= 1'b0;
  endtask : bq

  task automatic t_reset();
    rdc("raw", SDF_OFS_RAW, 32'h0);
    rdc("mask", SDF_OFS_MASK, 32'h0000_7fff);
    rdc("thr", SDF_OFS_THR, 32'h0000_0040);
    wr(SDF_OFS_RAW, 32'hffff_ffff);
    rdc("raw ro", SDF_OFS_RAW, 32'h0);
    rdc("clear reg", SDF_OFS_CLR, 32'h0);
    rdc("unmapped", 6'h10, 32'h0);
  endtask : t_reset

  task automatic t_card();
    int b[5] = '{SDF_B_REPLY_CRC, SDF_B_CMD_SENT, SDF_B_BUSY_REL, SDF_B_LINE3_LOW,
                 SDF_B_LINE3_HIGH};
    for (int k = 0; k < 5; k++) begin
      card.act(k);
      rdc("card event", SDF_OFS_RAW, 32'h1 << b[k]);
      wr(SDF_OFS_CLR, 32'h0);
      rdc("clear zero", SDF_OFS_RAW, 32'h1 << b[k]);
      wr(SDF_OFS_CLR, 32'h1 << b[k]);
      rdc("clear one", SDF_OFS_RAW, 32'h0);
    end
  endtask : t_card

  task automatic t_irq();
    wr(SDF_OFS_MASK, 32'h0000_77ff);
    irq_is("irq idle", 1'b0);
    card.act(1);
    irq_is("irq open", 1'b1);
    wr(SDF_OFS_MASK, 32'h0000_7fff);
    irq_is("irq masked", 1'b0);
    wr(SDF_OFS_MASK, 32'h0000_77ff);
    irq_is("irq again", 1'b1);
    wr(SDF_OFS_CLR, 32'h0000_0800);
    irq_is("irq cleared", 1'b0);
    wr(SDF_OFS_MASK, 32'h0000_7fff);
  endtask : t_irq

  task automatic t_qerr();
    card.act(6);
    flag("push room", SDF_B_CARD_RX_ERR, 1'b0);
    card.act(5);
    flag("pop empty", SDF_B_CARD_TX_ERR, 1'b1);
    lv(QB, 0);
    card.act(6);
    flag("push full", SDF_B_CARD_RX_ERR, 1'b1);
    lv(0, QB);
    bq(1'b0, SDF_SZ_WORD);
    flag("bus pop empty", SDF_B_BUS_RX_ERR, 1'b1);
    bq(1'b1, SDF_SZ_WORD);
    flag("bus push full", SDF_B_BUS_TX_ERR, 1'b1);
  endtask : t_qerr

  task automatic t_align();
    int eb[2] = '{SDF_B_BUS_RX_ERR, SDF_B_BUS_TX_ERR};
    lv(8, 8);
    wr(SDF_OFS_CLR, 32'h0000_7fff);
    for (int d = 0; d < 2; d++) begin
      bq(d[0], SDF_SZ_BYTE);
      flag("byte access", eb[d], 1'b0);
      bq(d[0], SDF_SZ_WORD);
      flag("word after byte", eb[d], 1'b1);
      // pointer now sits at byte one: a half access changes width off byte zero
      wr(SDF_OFS_CLR, 32'h0000_7fff);
      bq(d[0], SDF_SZ_HALF);
      flag("half after word", eb[d], 1'b1);
      wr(SDF_OFS_CLR, 32'h0000_7fff);
      bq(d[0], SDF_SZ_HALF);
      flag("half repeat", eb[d], 1'b0);
    end
  endtask : t_align

  task automatic t_levels();
    lv(0, QB);
    be_q = 4'h2;
    wr(SDF_OFS_THR, 32'h0000_20ff);
    rdc("rx thr lane", SDF_OFS_THR, 32'h0000_2040);
    be_q = 4'h1;
    wr(SDF_OFS_THR, 32'h0000_ff10);
    rdc("tx thr lane", SDF_OFS_THR, 32'h0000_2010);
    be_q = 4'hf;
    wr(SDF_OFS_CLR, 32'h0000_7fff);
    lv(1, QB);
    flag("rx not empty", SDF_B_RX_NONEMPTY, 1'b1);
    lv(32, QB);
    wr(SDF_OFS_CLR, 32'h0000_7fff);
    flag("rx at thr", SDF_B_RX_LEVEL, 1'b0);
    lv(33, QB);
    flag("rx over thr", SDF_B_RX_LEVEL, 1'b1);
    flag("rx not full", SDF_B_RX_FULL, 1'b0);
    lv(QB, 63);
    flag("rx full", SDF_B_RX_FULL, 1'b1);
    flag("tx left full", SDF_B_TX_SPACE, 1'b1);
    lv(QB, 48);
    wr(SDF_OFS_CLR, 32'h0000_7fff);
    flag("tx room at thr", SDF_B_TX_ROOM, 1'b0);
    lv(QB, 47);
    flag("tx room over", SDF_B_TX_ROOM, 1'b1);
    flag("tx not empty", SDF_B_TX_DRAINED, 1'b0);
    lv(QB, 0);
    flag("tx drained", SDF_B_TX_DRAINED, 1'b1);
  endtask : t_levels

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {miscompares, tests_run} = '0;
    {avs_read, avs_write, bus_rx_pop, bus_tx_push} = '0;
    {avs_address, avs_writedata, rx_level, tx_level} = '0;
    {bus_rx_size, bus_tx_size} = {SDF_SZ_WORD, SDF_SZ_WORD};
    avs_byteenable = 4'hf;
    be_q = 4'hf;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_card();
    t_irq();
    t_qerr();
    t_align();
    t_levels();
    end_of_test();
  end
endmodule : tb
